// ---- verilog/ispv_pkg.sv ----
// Constants for interrupt source arbitration and vectoring (priorities 18..37).
// Assumes one system clock domain; no software-visible registers here.
package ispv_pkg;
  // Number of maskable sources handled by this block
  localparam int NUM_SRC = 20;
  // Default priority of the first handled source
  localparam logic [5:0] PRIO_BASE = 6'h12;
  // Lowest possible default priority
  localparam logic [5:0] PRIO_LOWEST = 6'h25;
  // Vector address width
  localparam int VEC_W = 20;
  // Vector addresses of named sources
  localparam logic [19:0] VEC_TIMER0 = 20'h0002c;
  localparam logic [19:0] VEC_TIMER1 = 20'h0002e;
  localparam logic [19:0] VEC_RTC = 20'h00036;
  localparam logic [19:0] VEC_KEY = 20'h0003a;
  localparam logic [19:0] VEC_PWM_A = 20'h00056;
  localparam logic [19:0] VEC_PWM_B = 20'h00058;
  localparam logic [19:0] VEC_CAP_G = 20'h0005a;
  localparam logic [19:0] VEC_OVF_X = 20'h0005c;
  localparam logic [19:0] VEC_FLASH = 20'h00062;
  localparam logic [19:0] VEC_BREAK = 20'h0007e;
  localparam logic [19:0] VEC_RESET = 20'h00000;
  // Slot indexes (priority minus base)
  localparam int SLOT_TIMER0 = 0;
  localparam int SLOT_TIMER1 = 1;
  localparam int SLOT_RTC = 5;
  localparam int SLOT_KEY = 7;
  localparam int SLOT_PWM_A = 15;
  localparam int SLOT_PWM_B = 16;
  localparam int SLOT_CAP_G = 17;
  localparam int SLOT_OVF_X = 18;
  localparam int SLOT_FLASH = 19;
  // Key-return port lines; only the top five are wired out
  localparam int KEY_W = 8;
  localparam logic [7:0] KEY_CONNECTED_MASK = 8'hf8;
  // Illegal opcode and detector mode bit position
  localparam logic [7:0] OPC_ILLEGAL = 8'hff;
  localparam int DETECT_MODE_POS = 7;
  // Vector table per slot, slot 0 first
  localparam logic [19:0] VEC_TABLE [NUM_SRC] = '{
    20'h0002c, 20'h0002e, 20'h00030, 20'h00032, 20'h00034,
    20'h00036, 20'h00038, 20'h0003a, 20'h00040, 20'h0004a,
    20'h0004c, 20'h0004e, 20'h00050, 20'h00052, 20'h00052,
    20'h00056, 20'h00058, 20'h0005a, 20'h0005c, 20'h00062};
  // Vector kinds presented to the core
  typedef enum logic [1:0] {
    ISPV_NONE,
    ISPV_RESET,
    ISPV_BREAK,
    ISPV_MASKABLE
  } ispv_kind_e;
endpackage : ispv_pkg

// ---- verilog/ispv_arbiter.sv ----
// Fixed-priority picker over the maskable request slots.
// Assumes requests are synchronous levels; lowest index wins.
module ispv_arbiter #(
  parameter int N = 20
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [4:0]        idx
);
  import ispv_pkg::*;

  // Lowest set bit search, scanned from the top so the lowest index wins
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule : ispv_arbiter

// ---- verilog/ispv_top.sv ----
// Interrupt source arbitration and vectoring for priorities 18..37,
// software break and common reset vector.
// Assumes sources and core strobes are synchronous to sys_clk.
module ispv_top (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       timer0_done_req,
  input  wire logic                       timer1_count_end,
  input  wire logic                       timer1_capture_end,
  input  wire logic [ispv_pkg::NUM_SRC-1:0] other_src_req,
  input  wire logic                       rtc_fixed_cycle,
  input  wire logic                       rtc_alarm_match,
  input  wire logic [ispv_pkg::KEY_W-1:0] key_port_in,
  input  wire logic [3:0]                 pwm_timer_a_evt,
  input  wire logic [3:0]                 pwm_timer_b_evt,
  input  wire logic [3:0]                 capture_timer_g_evt,
  input  wire logic                       overflow_timer_x_req,
  input  wire logic                       flash_library_req,
  input  wire logic [ispv_pkg::NUM_SRC-1:0] src_mask,
  input  wire logic                       software_break,
  input  wire logic                       opcode_valid,
  input  wire logic [7:0]                 opcode,
  input  wire logic                       debug_emulation,
  input  wire logic                       voltage_detect_source,
  input  wire logic [7:0]                 detect_level_reg,
  input  wire logic                       ext_reset_req,
  input  wire logic                       power_on_req,
  input  wire logic                       watchdog_req,
  input  wire logic                       illegal_access_req,
  input  wire logic                       ram_parity_req,
  input  wire logic                       vector_ack,
  output logic                            vector_valid,
  output ispv_pkg::ispv_kind_e            vector_kind,
  output logic [ispv_pkg::VEC_W-1:0]      vector_addr,
  output logic [5:0]                      vector_prio,
  output logic                            voltage_detect_irq,
  output logic                            reset_out
);
  import ispv_pkg::*;

  // Merged request lines for each slot
  logic [NUM_SRC-1:0] merged_req;
  // Requests left after masking
  logic [NUM_SRC-1:0] live_req;
  // Key-return contribution after pin filtering
  wire                key_return_req;
  // Merged timer and clock requests
  wire                timer1_done_req;
  wire                rtc_event_req;
  wire                pwm_timer_a_req;
  wire                pwm_timer_b_req;
  wire                capture_timer_g_req;
  // Detector mode selects reset or interrupt
  wire                detector_mode_bit;
  // Reset sources
  wire                trap_reset;
  wire                detect_reset;
  wire                any_reset;
  // Arbiter result
  logic               win_any;
  logic [4:0]         win_idx;
  // Output registers
  logic               valid_reg;
  logic               valid_next;
  ispv_kind_e         kind_reg;
  ispv_kind_e         kind_next;
  logic [VEC_W-1:0]   addr_reg;
  logic [VEC_W-1:0]   addr_next;
  logic [5:0]         prio_reg;
  logic [5:0]         prio_next;
  logic               reset_reg;

  // Slot vector lookup for the maskable grant
  function automatic logic [VEC_W-1:0] slot_vector(input logic [4:0] s);
    return VEC_TABLE[s];
  endfunction : slot_vector

  // Event merging
  assign timer1_done_req     = timer1_count_end | timer1_capture_end;
  assign rtc_event_req       = rtc_fixed_cycle | rtc_alarm_match;
  // Unconnected key pins are ignored even if they float high
  assign key_return_req      = |(key_port_in & KEY_CONNECTED_MASK);
  assign pwm_timer_a_req     = |pwm_timer_a_evt;
  assign pwm_timer_b_req     = |pwm_timer_b_evt;
  assign capture_timer_g_req = |capture_timer_g_evt;

  // Detector mode and reset sources
  assign detector_mode_bit  = detect_level_reg[DETECT_MODE_POS];
  assign detect_reset       = voltage_detect_source & detector_mode_bit;
  assign voltage_detect_irq = voltage_detect_source & ~detector_mode_bit;
  // Debugger suppresses the illegal-opcode trap so breakpoints stay usable
  assign trap_reset = opcode_valid & (opcode == OPC_ILLEGAL) & ~debug_emulation;
  assign any_reset  = ext_reset_req | power_on_req | detect_reset | watchdog_req
                    | trap_reset | illegal_access_req | ram_parity_req;

  // Slot assembly; named slots override generic inputs
  always_comb begin
    merged_req              = other_src_req;
    merged_req[SLOT_TIMER0] = timer0_done_req;
    merged_req[SLOT_TIMER1] = timer1_done_req;
    merged_req[SLOT_RTC]    = rtc_event_req;
    merged_req[SLOT_KEY]    = key_return_req;
    merged_req[SLOT_PWM_A]  = pwm_timer_a_req;
    merged_req[SLOT_PWM_B]  = pwm_timer_b_req;
    merged_req[SLOT_CAP_G]  = capture_timer_g_req;
    merged_req[SLOT_OVF_X]  = overflow_timer_x_req;
    merged_req[SLOT_FLASH]  = flash_library_req;
    live_req                = merged_req & ~src_mask;
  end

  // Fixed-priority pick
  ispv_arbiter #(
    .N (NUM_SRC)
  ) u_arb (
    .req (live_req),
    .any (win_any),
    .idx (win_idx)
  );

  // Next vector: reset beats break beats maskable; a held vector waits for ack
  always_comb begin
    valid_next = valid_reg;
    kind_next  = kind_reg;
    addr_next  = addr_reg;
    prio_next  = prio_reg;
    if (valid_reg && !vector_ack) begin
      // Hold until taken
      valid_next = 1'b1;
    end else if (any_reset) begin
      valid_next = 1'b1;
      kind_next  = ISPV_RESET;
      addr_next  = VEC_RESET;
      prio_next  = 6'h00;
    end else if (software_break) begin
      valid_next = 1'b1;
      kind_next  = ISPV_BREAK;
      addr_next  = VEC_BREAK;
      prio_next  = 6'h00;
    end else if (win_any) begin
      valid_next = 1'b1;
      kind_next  = ISPV_MASKABLE;
      addr_next  = slot_vector(win_idx);
      prio_next  = PRIO_BASE + {1'b0, win_idx};
    end else begin
      valid_next = 1'b0;
      kind_next  = ISPV_NONE;
      addr_next  = VEC_RESET;
      prio_next  = 6'h00;
    end
  end

  // Reset preempts a held vector too: it must never wait on the core
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_reg <= 1'b0;
      kind_reg  <= ISPV_NONE;
      addr_reg  <= VEC_RESET;
      prio_reg  <= 6'h00;
      reset_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next | any_reset;
      kind_reg  <= any_reset ? ISPV_RESET : kind_next;
      addr_reg  <= any_reset ? VEC_RESET : addr_next;
      prio_reg  <= any_reset ? 6'h00 : prio_next;
      reset_reg <= any_reset;
    end
  end

  assign vector_valid = valid_reg;
  assign vector_kind  = kind_reg;
  assign vector_addr  = addr_reg;
  assign vector_prio  = prio_reg;
  assign reset_out    = reset_reg;

  // Checks
  a_prio_lowest_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!valid_reg || vector_ack) && !any_reset && !software_break && win_any
    |=> vector_prio == PRIO_BASE + {1'b0, $past(win_idx)}
        && ($past(live_req) & ((20'h00001 << $past(win_idx)) - 20'h00001)) == 20'h00000)
    else $error("Maskable grant not the smallest priority");
  a_timer0_vector: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!valid_reg || vector_ack) && !any_reset && !software_break && live_req[SLOT_TIMER0]
    |=> vector_addr == VEC_TIMER0 && vector_prio == 6'h12)
    else $error("Timer zero vector wrong");
  a_timer1_merge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!valid_reg || vector_ack) && !any_reset && !software_break && !live_req[0]
    && timer1_capture_end && !src_mask[SLOT_TIMER1]
    |=> vector_addr == VEC_TIMER1 && vector_prio == 6'h13)
    else $error("Timer one capture not vectored");
  a_key_pins_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (key_port_in & KEY_CONNECTED_MASK) == 8'h00 |-> !merged_req[SLOT_KEY])
    else $error("Unconnected key pin raised request");
  a_break_vector: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!valid_reg || vector_ack) && !any_reset && software_break
    |=> vector_valid && vector_kind == ISPV_BREAK && vector_addr == VEC_BREAK)
    else $error("Break vector wrong");
  a_trap_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opcode_valid && opcode == OPC_ILLEGAL && !debug_emulation |=> reset_out)
    else $error("Illegal opcode did not reset");
  a_trap_debug: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opcode_valid && debug_emulation && !ext_reset_req && !power_on_req && !watchdog_req
    && !illegal_access_req && !ram_parity_req && !detect_reset |=> !reset_out)
    else $error("Reset raised under debugger");
  a_detect_mode: assert property (@(posedge sys_clk) disable iff (!rst_b)
    voltage_detect_source && detect_level_reg[7]
    |=> reset_out && vector_addr == VEC_RESET && !$past(voltage_detect_irq))
    else $error("Voltage detect reset mode wrong");
  a_detect_irq: assert property (@(posedge sys_clk) disable iff (!rst_b)
    voltage_detect_source && !detect_level_reg[7] |-> voltage_detect_irq && !detect_reset)
    else $error("Voltage detect interrupt mode wrong");
  a_reset_common: assert property (@(posedge sys_clk) disable iff (!rst_b)
    watchdog_req || ram_parity_req || illegal_access_req
    |=> reset_out && vector_kind == ISPV_RESET && vector_addr == VEC_RESET)
    else $error("Reset source not on common vector");
endmodule : ispv_top

// ---- tb/ispv_core_model.sv ----
// Core-side model that takes offered interrupt vectors.
// Assumes vector outputs are registered on sys_clk; hold stalls it.
module ispv_core_model (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic hold,
  input  wire logic vector_valid,
  output logic      vector_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle ack per offer; hold lets the bench inspect a vector
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vector_ack <= 1'b0;
    end else begin
      vector_ack <= vector_valid & ~vector_ack & ~hold;
    end
  end
endmodule : ispv_core_model

// ---- tb/ispv_top_tb.sv ----
// Self-checking bench for the vector arbiter top.
// Assumes the core model acks offered vectors unless held.
module ispv_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ispv_pkg::*;
  logic sys_clk = 0, rst_b = 0, hold = 1, vector_ack;            // Clock, reset, stall
  logic t0 = 0, t1c = 0, t1p = 0, rtf = 0, rta = 0, tx = 0, fl = 0; // Named requests
  logic swb = 0, opv = 0, dbg = 0, vds = 0;                      // Core and detector
  logic ext = 0, por = 0, wdt = 0, iaw = 0, rpe = 0;             // Reset sources
  logic [19:0] oth = '0, msk = '0;                               // Generic slots, mask
  logic [7:0]  key = '0, opc = 8'hff, lvl = 8'h80;               // Key port, opcode, level
  logic [3:0]  pa = '0, pb = '0, cg = '0;                        // Merged timer events
  logic vector_valid, voltage_detect_irq, reset_out;
  ispv_kind_e  vector_kind;
  logic [19:0] vector_addr;
  logic [5:0]  vector_prio;
  int err_total = 0, total_checks = 0;
  // Slot, vector and priority table of the named sources
  int          slot_t [9] = '{0, 1, 5, 7, 15, 16, 17, 18, 19};
  logic [19:0] addr_t [9] = '{20'h0002c, 20'h0002e, 20'h00036, 20'h0003a, 20'h00056,
                              20'h00058, 20'h0005a, 20'h0005c, 20'h00062};
  logic [5:0]  prio_t [9] = '{6'h12, 6'h13, 6'h17, 6'h19, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25};
  always #2.5 sys_clk = ~sys_clk;
  ispv_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .timer0_done_req(t0),
    .timer1_count_end(t1c), .timer1_capture_end(t1p), .other_src_req(oth),
    .rtc_fixed_cycle(rtf), .rtc_alarm_match(rta), .key_port_in(key),
    .pwm_timer_a_evt(pa), .pwm_timer_b_evt(pb), .capture_timer_g_evt(cg),
    .overflow_timer_x_req(tx), .flash_library_req(fl), .src_mask(msk),
    .software_break(swb), .opcode_valid(opv), .opcode(opc), .debug_emulation(dbg),
    .voltage_detect_source(vds), .detect_level_reg(lvl), .ext_reset_req(ext),
    .power_on_req(por), .watchdog_req(wdt), .illegal_access_req(iaw),
    .ram_parity_req(rpe), .vector_ack(vector_ack), .vector_valid(vector_valid),
    .vector_kind(vector_kind), .vector_addr(vector_addr), .vector_prio(vector_prio),
    .voltage_detect_irq(voltage_detect_irq), .reset_out(reset_out));
  ispv_core_model u_core (.sys_clk(sys_clk), .rst_b(rst_b), .hold(hold),
    .vector_valid(vector_valid), .vector_ack(vector_ack));
  // Single compare point; counts every check
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  // Drive one request line of a slot; b picks the merged event
  task automatic drive(input int s, input int b, input logic v);
    case (s)
      0: t0 <= v;
      1: if (b[0]) t1p <= v; else t1c <= v;
      5: if (b[0]) rta <= v; else rtf <= v;
      7: key[b+4] <= v;                     // Connected key lines only
      15: pa[b] <= v;
      16: pb[b] <= v;
      17: cg[b] <= v;
      18: tx <= v;
      19: fl <= v;
      default: oth[s] <= v;                 // Unnamed slots
    endcase
  endtask : drive
  // Wait, bounded, for an offered vector and judge it
  task automatic expect_vec(input logic [1:0] k, input logic [19:0] a, input logic [5:0] p);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (vector_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(vector_kind, k);
    chk(vector_addr, a);
    chk(vector_prio, p);
  endtask : expect_vec
  // Let the core take one vector, then stall again
  task automatic next_vec();
    @(posedge sys_clk) hold <= 1'b0;
    @(posedge sys_clk) hold <= 1'b1;
    @(posedge sys_clk);
  endtask : next_vec
  // Let the core drain everything, bounded
  task automatic release_idle();
    int n;
    n = 0;
    @(posedge sys_clk) hold <= 1'b0;
    while (vector_valid !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk) hold <= 1'b1;
  endtask : release_idle
  // Every named source and every merged event alone, key lines 7..4 only
  task automatic t_slots();
    for (int i = 0; i < 9; i++) begin
      for (int b = 0; b < 4; b++) begin
        @(posedge sys_clk) drive(slot_t[i], b, 1'b1);
        expect_vec(ISPV_MASKABLE, addr_t[i], prio_t[i]);
        @(posedge sys_clk) drive(slot_t[i], b, 1'b0);
        release_idle();
      end
    end
  endtask : t_slots
  // Simultaneous requests, masked slot skipped, break outranks
  task automatic t_prio();
    @(posedge sys_clk) begin t0 <= 1; oth[2] <= 1; tx <= 1; fl <= 1; end
    expect_vec(ISPV_MASKABLE, 20'h0002c, 6'h12);
    @(posedge sys_clk) t0 <= 0;
    next_vec();
    expect_vec(ISPV_MASKABLE, 20'h00030, 6'h14);
    @(posedge sys_clk) begin oth[2] <= 0; msk[18] <= 1; end
    next_vec();
    expect_vec(ISPV_MASKABLE, 20'h00062, 6'h25);
    @(posedge sys_clk) begin fl <= 0; msk[18] <= 0; end
    next_vec();
    expect_vec(ISPV_MASKABLE, 20'h0005c, 6'h24);
    @(posedge sys_clk) begin tx <= 0; swb <= 1; t0 <= 1; end
    next_vec();
    expect_vec(ISPV_BREAK, 20'h0007e, 6'h00);
    @(posedge sys_clk) begin swb <= 0; t0 <= 0; end
    release_idle();
  endtask : t_prio
  // One-cycle pulse on a reset-type source, then judge
  task automatic rst_case(input int s, input logic exp);
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk);
      case (s)
        0: ext <= v[0];
        1: por <= v[0];
        2: wdt <= v[0];
        3: iaw <= v[0];
        4: rpe <= v[0];
        5: opv <= v[0];
        default: vds <= v[0];
      endcase
    end
    @(negedge sys_clk);
    chk(reset_out, exp);
    if (exp) begin
      chk(vector_kind, ISPV_RESET);
      chk(vector_addr, 20'h00000);
    end
    release_idle();
  endtask : rst_case
  // Reset sources, debugger, detector mode and key lines
  task automatic t_resets();
    for (int s = 0; s < 7; s++) rst_case(s, 1'b1);
    // A legal opcode must never trap
    @(posedge sys_clk) opc <= 8'h7e;
    rst_case(5, 1'b0);
    @(posedge sys_clk) begin opc <= 8'hff; dbg <= 1; end
    rst_case(5, 1'b0);
    @(posedge sys_clk) lvl <= 8'h7f;
    rst_case(6, 1'b0);
    @(posedge sys_clk) vds <= 1;
    @(negedge sys_clk) chk(voltage_detect_irq, 1'b1);
    @(posedge sys_clk) lvl <= 8'h80;
    @(negedge sys_clk) chk(voltage_detect_irq, 1'b0);
    // Mode bit now set, so the held detector level issues a reset vector
    @(posedge sys_clk) vds <= 0;
    @(negedge sys_clk) chk(reset_out, 1'b1);
    release_idle();
    @(posedge sys_clk) key[2:0] <= 3'h7;
    repeat (4) @(negedge sys_clk);
    chk(vector_valid, 1'b0);
    release_idle();
    @(posedge sys_clk) key[3] <= 1;
    expect_vec(ISPV_MASKABLE, 20'h0003a, 6'h19);
    @(posedge sys_clk) key <= '0;
    release_idle();
  endtask : t_resets
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_slots();
    t_prio();
    t_resets();
    test_done();
  end
  // Hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
endmodule : ispv_top_tb
